// *** hw/addr_filter.sv ***
// destination address filter decision for one received frame
module addr_filter
    import mac_ctrl_pkg::*;
(
    // control
    input  wire logic [31:0] i_ctrl,
    input  wire logic [63:0] i_hash,
    input  wire logic [47:0] i_station,
    // frame destination
    input  wire logic [47:0] i_dest,
    // decision
    output logic             o_pass
);
    function automatic logic [5:0] hash_index(input logic [47:0] a);
        logic [31:0] crc;
        logic        fb;
        crc = 32'hFFFFFFFF;
        for (int i = 0; i < 48; i++) begin
            fb  = crc[31] ^ a[i];
            crc = {crc[30:0], 1'b0};
            if (fb) crc = crc ^ 32'h04C11DB7;
        end
        return crc[31:26];
    endfunction

    logic       mcast;
    logic       exact;
    logic       hashed;
    logic [5:0] idx;

    always_comb begin
        mcast  = i_dest[0];
        exact  = (i_dest == i_station);
        idx    = hash_index(i_dest);
        hashed = i_hash[idx];
        o_pass = 1'b0;
        if (i_ctrl[BIT_ACCEPT_ANY]) begin
            o_pass = 1'b1;
        end else if (mcast && i_ctrl[BIT_PASS_MCAST]) begin
            o_pass = 1'b1;
        end else if (!i_ctrl[BIT_HASH_SEL]) begin
            // inversion only meaningful for exact matching
            o_pass = exact ^ i_ctrl[BIT_INVERSE];
        end else if (mcast || i_ctrl[BIT_HASH_ONLY]) begin
            o_pass = hashed;
        end else begin
            o_pass = exact;
        end
    end
endmodule

// *** hw/loop_mux.sv ***
// loopback steering between MAC transmit, PHY and MAC receive
module loop_mux (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    // control
    input  wire logic i_loop,
    // streams
    frame_if.dst      mac_tx,
    frame_if.dst      phy_rx,
    frame_if.src      to_phy,
    frame_if.src      to_rx
);
    typedef struct packed {
        logic       tv;
        logic [7:0] td;
        logic       tl;
        logic       te;
        logic       rv;
        logic [7:0] rd;
        logic       rl;
        logic       re;
    } mux_state_t;
    mux_state_t st_reg;
    mux_state_t st_next;

    always_comb begin
        st_next = '0;
        if (i_loop) begin
            // frame turned back, PHY sees nothing
            st_next.rv = mac_tx.valid;
            st_next.rd = mac_tx.data;
            st_next.rl = mac_tx.last;
            st_next.re = mac_tx.error;
        end else begin
            st_next.tv = mac_tx.valid;
            st_next.td = mac_tx.data;
            st_next.tl = mac_tx.last;
            st_next.te = mac_tx.error;
            st_next.rv = phy_rx.valid;
            st_next.rd = phy_rx.data;
            st_next.rl = phy_rx.last;
            st_next.re = phy_rx.error;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign to_phy.valid = st_reg.tv;
    assign to_phy.data  = st_reg.td;
    assign to_phy.last  = st_reg.tl;
    assign to_phy.error = st_reg.te;
    assign to_rx.valid  = st_reg.rv;
    assign to_rx.data   = st_reg.rd;
    assign to_rx.last   = st_reg.rl;
    assign to_rx.error  = st_reg.re;
endmodule

// *** hw/mac_rx_filter_mode_control.sv ***
// MAC mode control: control register, loopback, filtering, collision policy
//
// The plain strobed port and the register addresses are this design's own decisions.
module mac_rx_filter_mode_control
    import mac_ctrl_pkg::*;
#(
    parameter int SETTLE_CYCLES = LOOP_SETTLE_CYC
) (
    // clock and reset
    input  wire logic        I_CLOCK,
    input  wire logic        I_ARST_N,
    // register port
    input  wire logic [7:0]  I_ADDR,
    input  wire logic [31:0] I_WDATA,
    input  wire logic        I_WR,
    input  wire logic        I_RD,
    output logic      [31:0] O_RDATA,
    // MAC transmit stream in
    input  wire logic        I_TX_VALID,
    input  wire logic [7:0]  I_TX_DATA,
    input  wire logic        I_TX_LAST,
    input  wire logic        I_TX_ERR,
    // transmit collision indications
    input  wire logic        I_TX_COLL,
    input  wire logic        I_TX_LATE,
    // PHY receive stream in
    input  wire logic        I_PHY_VALID,
    input  wire logic [7:0]  I_PHY_DATA,
    input  wire logic        I_PHY_LAST,
    input  wire logic        I_PHY_ERR,
    // PHY transmit stream out
    output logic             O_PHY_VALID,
    output logic [7:0]       O_PHY_DATA,
    output logic             O_PHY_LAST,
    output logic             O_PHY_ERR,
    // received frame decision
    output logic             O_RX_ACCEPT,
    output logic             O_RX_DROP,
    // transmit decisions and status
    output logic             O_TX_RETRY,
    output logic             O_TX_ABORT,
    output logic             O_TX_LATE_STAT,
    output logic             O_RX_BLOCK_OWN
);
    // ***********************************************************
    // reset release
    // ***********************************************************
    logic [1:0] rst_sync_reg;
    logic       rst_n;
    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // ***********************************************************
    // loopback path
    // ***********************************************************
    frame_if mac_tx ();
    frame_if phy_rx ();
    frame_if to_phy ();
    frame_if to_rx  ();
    assign mac_tx.valid = I_TX_VALID;
    assign mac_tx.data  = I_TX_DATA;
    assign mac_tx.last  = I_TX_LAST;
    assign mac_tx.error = I_TX_ERR;
    assign phy_rx.valid = I_PHY_VALID;
    assign phy_rx.data  = I_PHY_DATA;
    assign phy_rx.last  = I_PHY_LAST;
    assign phy_rx.error = I_PHY_ERR;

    typedef struct packed {
        logic [31:0]         ctrl;
        logic [31:0]         hash_hi;
        logic [31:0]         hash_lo;
        logic [31:0]         sta_hi;
        logic [31:0]         sta_lo;
        logic [31:0]         rdata;
        logic                loop_eff;
        logic [SETTLE_W-1:0] settle;
        logic [47:0]         dest;
        logic [2:0]          dcnt;
        logic                in_frame;
        logic                accept;
        logic                drop;
        logic                retry;
        logic                abort;
        logic                late_stat;
        logic                block_own;
        logic                tv;
        logic [7:0]          td;
        logic                tl;
        logic                te;
    } top_state_t;
    top_state_t s_reg;
    top_state_t s_next;

    loop_mux u_loop (
        .i_clk   (I_CLOCK),
        .i_rst_n (rst_n),
        .i_loop  (s_reg.loop_eff),
        .mac_tx  (mac_tx),
        .phy_rx  (phy_rx),
        .to_phy  (to_phy),
        .to_rx   (to_rx)
    );

    // ***********************************************************
    // address filter
    // ***********************************************************
    logic        pass;
    logic [47:0] dest_now;
    assign dest_now = (s_reg.dcnt == 3'd5) ?
        {to_rx.data, s_reg.dest[39:0]} : s_reg.dest;

    addr_filter u_filt (
        .i_ctrl    (s_reg.ctrl),
        .i_hash    ({s_reg.hash_hi, s_reg.hash_lo}),
        .i_station ({s_reg.sta_hi[15:0], s_reg.sta_lo}),
        .i_dest    (dest_now),
        .o_pass    (pass)
    );

    // ***********************************************************
    // next state
    // ***********************************************************
    logic [SETTLE_W-1:0] settle_len;
    assign settle_len = SETTLE_W'(SETTLE_CYCLES);

    always_comb begin
        s_next = s_reg;
        s_next.accept = 1'b0;
        s_next.drop   = 1'b0;
        s_next.retry  = 1'b0;
        s_next.abort  = 1'b0;
        s_next.late_stat = 1'b0;
        s_next.rdata  = 32'h00000000;
        // register writes
        if (I_WR) begin
            case (I_ADDR)
                OFF_MAC_CONTROL: begin
                    s_next.ctrl = I_WDATA & CTRL_WRITE_MASK;
                    if (I_WDATA[BIT_LOOPBACK] !=
                        s_reg.ctrl[BIT_LOOPBACK]) begin
                        s_next.settle = settle_len;
                    end
                end
                OFF_HASH_HIGH:  s_next.hash_hi = I_WDATA;
                OFF_HASH_LOW:   s_next.hash_lo = I_WDATA;
                OFF_STATION_HI: s_next.sta_hi  = {16'h0000, I_WDATA[15:0]};
                OFF_STATION_LO: s_next.sta_lo  = I_WDATA;
                default: ;
            endcase
        end
        // register reads
        if (I_RD) begin
            case (I_ADDR)
                OFF_MAC_CONTROL: s_next.rdata = s_reg.ctrl;
                OFF_HASH_HIGH:   s_next.rdata = s_reg.hash_hi;
                OFF_HASH_LOW:    s_next.rdata = s_reg.hash_lo;
                OFF_STATION_HI:  s_next.rdata = s_reg.sta_hi;
                OFF_STATION_LO:  s_next.rdata = s_reg.sta_lo;
                OFF_MODE_STATUS:
                    s_next.rdata = {30'h00000000,
                                    s_reg.settle != '0, s_reg.loop_eff};
                default:         s_next.rdata = 32'h00000000;
            endcase
        end
        // loopback takes effect once settling ends; change is not instant
        if (s_reg.settle != '0) begin
            s_next.settle = s_reg.settle - 1'b1;
            if (s_reg.settle == SETTLE_W'(1)) begin
                s_next.loop_eff = s_reg.ctrl[BIT_LOOPBACK];
            end
        end
        // half duplex: ignore own transmission on the receive side
        s_next.block_own = I_TX_VALID && !s_reg.ctrl[BIT_FULL_DUPLEX]
                           && !s_reg.loop_eff;
        // destination capture and decision at frame end
        if (to_rx.valid && !s_reg.block_own) begin
            if (s_reg.dcnt < 3'd6) begin
                s_next.dest[s_reg.dcnt*8 +: 8] = to_rx.data;
                s_next.dcnt = s_reg.dcnt + 3'd1;
            end
            if (s_reg.dcnt == 3'd5) begin
                s_next.in_frame = pass;
            end
            if (to_rx.last) begin
                s_next.dcnt = 3'd0;
                // runts never reach six bytes and are dropped unless BIT_PASS_ERR and BIT_ACCEPT_ANY are both set
                if ((s_reg.dcnt == 3'd5 ? pass : s_reg.in_frame)
                    && s_reg.dcnt >= 3'd5
                    && (!to_rx.error || s_reg.ctrl[BIT_PASS_ERR])) begin
                    s_next.accept = 1'b1;
                end else if (s_reg.ctrl[BIT_PASS_ERR] && s_reg.dcnt < 3'd5
                             && s_reg.ctrl[BIT_ACCEPT_ANY]) begin
                    s_next.accept = 1'b1;
                end else begin
                    s_next.drop = 1'b1;
                end
                s_next.in_frame = 1'b0;
            end
        end
        // late collision policy
        if (I_TX_COLL && I_TX_LATE) begin
            s_next.late_stat = 1'b1;
            if (s_reg.ctrl[BIT_LATE_RETRY]) begin
                s_next.retry = 1'b1;
            end else begin
                s_next.abort = 1'b1;
            end
        end else if (I_TX_COLL) begin
            s_next.retry = 1'b1;
        end
        // PHY output registered once more so all outputs are flops
        s_next.tv = to_phy.valid;
        s_next.td = to_phy.data;
        s_next.tl = to_phy.last;
        s_next.te = to_phy.error;
    end

    always_ff @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            s_reg      <= '0;
            s_reg.ctrl <= CTRL_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // ***********************************************************
    // outputs
    // ***********************************************************
    assign O_RDATA        = s_reg.rdata;
    assign O_PHY_VALID    = s_reg.tv;
    assign O_PHY_DATA     = s_reg.td;
    assign O_PHY_LAST     = s_reg.tl;
    assign O_PHY_ERR      = s_reg.te;
    assign O_RX_ACCEPT    = s_reg.accept;
    assign O_RX_DROP      = s_reg.drop;
    assign O_TX_RETRY     = s_reg.retry;
    assign O_TX_ABORT     = s_reg.abort;
    assign O_TX_LATE_STAT = s_reg.late_stat;
    assign O_RX_BLOCK_OWN = s_reg.block_own;
endmodule

// *** shared/frame_if.sv ***
// interface: one MII-side frame byte stream with frame markers
interface frame_if;
    logic       valid;
    logic [7:0] data;
    logic       last;
    logic       error;
    modport src (output valid, output data, output last, output error);
    modport dst (input valid, input data, input last, input error);
endinterface

// *** shared/mac_ctrl_pkg.sv ***
// package: register map, field positions, reset values, timing counts
package mac_ctrl_pkg;
    // ***********************************************************
    // register offsets (byte addresses)
    // ***********************************************************
    localparam logic [7:0] OFF_MAC_CONTROL = 8'h80;
    localparam logic [7:0] OFF_HASH_HIGH   = 8'h8C;
    localparam logic [7:0] OFF_HASH_LOW    = 8'h90;
    localparam logic [7:0] OFF_STATION_HI  = 8'h84;
    localparam logic [7:0] OFF_STATION_LO  = 8'h88;
    localparam logic [7:0] OFF_MODE_STATUS = 8'hC0;
    // ***********************************************************
    // mac_control field positions
    // ***********************************************************
    localparam int BIT_LOOPBACK    = 21;
    localparam int BIT_FULL_DUPLEX = 20;
    localparam int BIT_PASS_MCAST  = 19;
    localparam int BIT_ACCEPT_ANY  = 18;
    localparam int BIT_INVERSE     = 17;
    localparam int BIT_PASS_ERR    = 16;
    localparam int BIT_HASH_ONLY   = 15;
    localparam int BIT_HASH_SEL    = 13;
    localparam int BIT_LATE_RETRY  = 12;
    localparam logic [31:0] CTRL_WRITE_MASK = 32'h003FB000;
    localparam logic [31:0] CTRL_RESET      = 32'h00040000;
    // ***********************************************************
    // timing
    // ***********************************************************
    localparam int CLK_PERIOD_PS    = 5000;
    localparam int LOOP_SETTLE_NS   = 10000;
    localparam int LOOP_SETTLE_CYC  =
        (LOOP_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SETTLE_W         = 12;
endpackage

// *** testbench/mac_phy_model.sv ***
// partner model: internal PHY that sends receive frames and counts tx bytes
module mac_phy_model (
    // clock
    input  wire logic        i_clk,
    // transmit stream from the MAC
    input  wire logic        i_valid,
    // receive stream to the MAC
    output logic             o_valid,
    output logic [7:0]       o_data,
    output logic             o_last,
    output logic             o_err,
    // bytes seen on the transmit stream
    output logic [15:0]      o_got
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] byte_reg;
    logic [7:0] idle_reg;
    // idle data toggles so a stale byte can never look valid
    assign o_data = o_valid ? byte_reg : idle_reg;
    initial begin
        o_valid = 1'b0;
        o_last = 1'b0;
        o_err = 1'b0;
        o_got = 16'h0;
        idle_reg = 8'h00;
        byte_reg = 8'h00;
    end
    always @(posedge i_clk) begin
        idle_reg <= ~idle_reg;
        if (i_valid) begin
            o_got <= o_got + 16'h1;
        end
    end
    task automatic send(input logic [47:0] d, input logic e);
        for (int i = 0; i < 8; i++) begin
            @(posedge i_clk);
            o_valid <= 1'b1;
            byte_reg <= (i < 6) ? d[8*i +: 8] : 8'hC3;
            o_last <= (i == 7);
            o_err <= e && (i == 7);
        end
        @(posedge i_clk);
        o_valid <= 1'b0;
        o_last <= 1'b0;
        o_err <= 1'b0;
    endtask
endmodule

// *** testbench/mac_rx_filter_mode_control_chk.sv ***
// checker: port-level properties of the MAC mode control block
module mac_ctrl_chk
    import mac_ctrl_pkg::*;
#(
    parameter int SETTLE_CYCLES = LOOP_SETTLE_CYC
) (
    // clock and reset
    input wire logic        I_CLOCK,
    input wire logic        I_ARST_N,
    // register port
    input wire logic [7:0]  I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic        I_WR,
    input wire logic        I_RD,
    input wire logic [31:0] O_RDATA,
    // streams and status
    input wire logic        I_TX_VALID,
    input wire logic [7:0]  I_TX_DATA,
    input wire logic        I_TX_LAST,
    input wire logic        I_TX_COLL,
    input wire logic        I_TX_LATE,
    input wire logic        I_PHY_VALID,
    input wire logic        I_PHY_LAST,
    input wire logic        I_PHY_ERR,
    input wire logic        O_PHY_VALID,
    input wire logic [7:0]  O_PHY_DATA,
    input wire logic        O_PHY_LAST,
    input wire logic        O_RX_ACCEPT,
    input wire logic        O_RX_DROP,
    input wire logic        O_TX_RETRY,
    input wire logic        O_TX_ABORT,
    input wire logic        O_TX_LATE_STAT,
    input wire logic        O_RX_BLOCK_OWN
);
    // ********************************
    // shadow of control, settle age
    // ********************************
    logic [31:0] ctrl_reg;
    logic [15:0] age_reg;
    logic [3:0]  bcnt_reg;
    logic        settled;
    logic        rx_ok;
    logic        fin;
    assign settled = int'(age_reg) > SETTLE_CYCLES + 4;
    assign rx_ok = !ctrl_reg[BIT_LOOPBACK] && settled && !O_RX_BLOCK_OWN;
    assign fin = I_PHY_VALID && I_PHY_LAST;
    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            ctrl_reg <= CTRL_RESET;
            age_reg <= 16'hFFFF;
            bcnt_reg <= 4'h0;
        end else begin
            if (I_WR && I_ADDR == OFF_MAC_CONTROL) begin
                ctrl_reg <= I_WDATA & CTRL_WRITE_MASK;
            end
            if (I_WR && I_ADDR == OFF_MAC_CONTROL &&
                I_WDATA[BIT_LOOPBACK] != ctrl_reg[BIT_LOOPBACK]) begin
                age_reg <= 16'h0;
            end else if (age_reg != 16'hFFFF) begin
                age_reg <= age_reg + 16'h1;
            end
            if (fin) begin
                bcnt_reg <= 4'h0;
            end else if (I_PHY_VALID && bcnt_reg != 4'hF) begin
                bcnt_reg <= bcnt_reg + 4'h1;
            end
        end
    end
    // ********************************
    // properties
    // ********************************
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_ARST_N);
    a_ctrl_read_back: assert property (
        I_RD && I_ADDR == OFF_MAC_CONTROL |=> O_RDATA == $past(ctrl_reg))
        else $error("control read data differs from written value");
    a_late_stat_always: assert property (
        I_TX_COLL && I_TX_LATE |=> O_TX_LATE_STAT)
        else $error("late collision not reported");
    a_late_retry_on: assert property (
        I_TX_COLL && I_TX_LATE && ctrl_reg[BIT_LATE_RETRY]
        |=> O_TX_RETRY && !O_TX_ABORT)
        else $error("late collision not retried");
    a_late_abort_off: assert property (
        I_TX_COLL && I_TX_LATE && !ctrl_reg[BIT_LATE_RETRY]
        |=> O_TX_ABORT && !O_TX_RETRY)
        else $error("late collision not abandoned");
    a_loop_phy_quiet: assert property (
        ctrl_reg[BIT_LOOPBACK] && settled |-> !O_PHY_VALID)
        else $error("looped frame reached the PHY");
    a_phy_forward: assert property (
        !ctrl_reg[BIT_LOOPBACK] && settled && $past(I_TX_VALID, 2)
        |-> O_PHY_VALID && O_PHY_DATA == $past(I_TX_DATA, 2))
        else $error("transmit byte not forwarded to PHY");
    a_phy_last_fwd: assert property (
        !ctrl_reg[BIT_LOOPBACK] && settled && $past(I_TX_VALID, 2)
        |-> O_PHY_LAST == $past(I_TX_LAST, 2))
        else $error("transmit frame end not forwarded to PHY");
    a_any_accept: assert property (
        rx_ok && ctrl_reg[BIT_ACCEPT_ANY] && fin && !I_PHY_ERR &&
        bcnt_reg >= 4'h5 |-> ##2 O_RX_ACCEPT)
        else $error("frame refused with any destination accepted");
    a_bad_drop: assert property (
        rx_ok && !ctrl_reg[BIT_PASS_ERR] && fin && I_PHY_ERR
        |-> ##2 O_RX_DROP)
        else $error("bad frame kept");
    a_duplex_no_block: assert property (
        ctrl_reg[BIT_FULL_DUPLEX] |=> !O_RX_BLOCK_OWN)
        else $error("receive blocked in full duplex");
    c_late_retry: cover property (O_TX_RETRY && O_TX_LATE_STAT);
    c_loop_tx: cover property (ctrl_reg[BIT_LOOPBACK] && I_TX_VALID);
    c_accept: cover property (O_RX_ACCEPT);
endmodule

bind mac_rx_filter_mode_control mac_ctrl_chk #(
    .SETTLE_CYCLES(SETTLE_CYCLES)
) u_chk (
    .I_CLOCK(I_CLOCK), .I_ARST_N(I_ARST_N), .I_ADDR(I_ADDR),
    .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
    .I_TX_VALID(I_TX_VALID), .I_TX_DATA(I_TX_DATA),
    .I_TX_LAST(I_TX_LAST), .O_PHY_LAST(O_PHY_LAST),
    .I_TX_COLL(I_TX_COLL), .I_TX_LATE(I_TX_LATE),
    .I_PHY_VALID(I_PHY_VALID), .I_PHY_LAST(I_PHY_LAST),
    .I_PHY_ERR(I_PHY_ERR), .O_PHY_VALID(O_PHY_VALID),
    .O_PHY_DATA(O_PHY_DATA), .O_RX_ACCEPT(O_RX_ACCEPT),
    .O_RX_DROP(O_RX_DROP), .O_TX_RETRY(O_TX_RETRY),
    .O_TX_ABORT(O_TX_ABORT), .O_TX_LATE_STAT(O_TX_LATE_STAT),
    .O_RX_BLOCK_OWN(O_RX_BLOCK_OWN)
);

// *** testbench/mac_rx_filter_mode_control_tb.sv ***
// testbench: register, filter, loopback and collision scenarios
module mac_rx_filter_mode_control_tb;
    import mac_ctrl_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SETTLE = 20;
    localparam logic [31:0] FDX = 32'h1 << BIT_FULL_DUPLEX;
    localparam logic [31:0] LOOP = 32'h1 << BIT_LOOPBACK;
    localparam logic [31:0] MCA = 32'h1 << BIT_PASS_MCAST;
    localparam logic [31:0] ANY = 32'h1 << BIT_ACCEPT_ANY;
    localparam logic [31:0] INV = 32'h1 << BIT_INVERSE;
    localparam logic [31:0] PERR = 32'h1 << BIT_PASS_ERR;
    localparam logic [31:0] HO = 32'h1 << BIT_HASH_ONLY;
    localparam logic [31:0] HSEL = 32'h1 << BIT_HASH_SEL;
    localparam logic [31:0] LRT = 32'h1 << BIT_LATE_RETRY;
    localparam logic [47:0] STN = 48'h554433221102;
    localparam logic [47:0] OTH = 48'h554433221104;
    localparam logic [47:0] MC = 48'h0100005E0001;
    logic        clk, arst_n, wr, rd, tx_v, tx_l, coll, late;
    logic        p_v, p_l, p_e, acc, drop, retry, abort, lstat;
    logic [7:0]  addr, tx_d, p_d;
    logic [31:0] wdata, rdata;
    logic [15:0] got, base;
    int          fail_count, checked;
    mac_rx_filter_mode_control #(.SETTLE_CYCLES(SETTLE)) DUT (
        .I_CLOCK(clk), .I_ARST_N(arst_n), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
        .I_TX_VALID(tx_v), .I_TX_DATA(tx_d), .I_TX_LAST(tx_l),
        .I_TX_ERR(1'b0), .I_TX_COLL(coll), .I_TX_LATE(late),
        .I_PHY_VALID(p_v), .I_PHY_DATA(p_d), .I_PHY_LAST(p_l),
        .I_PHY_ERR(p_e), .O_PHY_VALID(), .O_PHY_DATA(),
        .O_PHY_LAST(), .O_PHY_ERR(), .O_RX_ACCEPT(acc),
        .O_RX_DROP(drop), .O_TX_RETRY(retry), .O_TX_ABORT(abort),
        .O_TX_LATE_STAT(lstat), .O_RX_BLOCK_OWN()
    );
    mac_phy_model u_phy (
        .i_clk(clk), .i_valid(DUT.O_PHY_VALID), .o_valid(p_v),
        .o_data(p_d), .o_last(p_l), .o_err(p_e), .o_got(got)
    );
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic final_report();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] seen);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check("rdata", exp, rdata);
    endtask
    task automatic rx_verdict(input logic exp);
        int n;
        n = 0;
        #1;
        while (acc !== 1'b1 && drop !== 1'b1 && n < 12) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (acc !== 1'b1 && drop !== 1'b1) begin
            fail_count++;
            final_report();
        end
        check("rx_accept_drop", {30'h0, exp, !exp}, {30'h0, acc, drop});
    endtask
    task automatic filt(input logic [31:0] c, input logic [31:0] h,
                        input logic [47:0] d, input logic e, input logic x);
        wr_reg(OFF_MAC_CONTROL, c);
        wr_reg(OFF_HASH_HIGH, h);
        wr_reg(OFF_HASH_LOW, h);
        u_phy.send(d, e);
        rx_verdict(x);
    endtask
    task automatic tx_frame(input logic [47:0] d);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            tx_v <= 1'b1;
            tx_d <= (i < 6) ? d[8*i +: 8] : 8'h5A;
            tx_l <= (i == 7);
        end
        @(posedge clk);
        tx_v <= 1'b0;
        tx_l <= 1'b0;
    endtask
    task automatic coll_chk(input logic lt, input logic [2:0] exp);
        @(posedge clk);
        coll <= 1'b1;
        late <= lt;
        @(posedge clk);
        coll <= 1'b0;
        #1;
        check("retry_abort_stat", {29'h0, exp}, {29'h0, retry, abort, lstat});
    endtask
    initial begin
        {arst_n, wr, rd, tx_v, tx_l, coll, late} = '0;
        {addr, tx_d, wdata} = '0;
        fail_count = 0;
        checked = 0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        // ****************************
        // registers
        // ****************************
        rd_chk(OFF_MAC_CONTROL, CTRL_RESET);
        wr_reg(OFF_MAC_CONTROL, ~LOOP);
        rd_chk(OFF_MAC_CONTROL, CTRL_WRITE_MASK & ~LOOP);
        wr_reg(OFF_HASH_HIGH, 32'hA5A5F00F);
        wr_reg(OFF_HASH_LOW, 32'h0FF05A5A);
        rd_chk(OFF_HASH_HIGH, 32'hA5A5F00F);
        rd_chk(OFF_HASH_LOW, 32'h0FF05A5A);
        rd_chk(8'hC4, 32'h0);
        wr_reg(OFF_STATION_HI, 32'h00005544);
        wr_reg(OFF_STATION_LO, 32'h33221102);
        $display("test registers done");
        // ****************************
        // destination filtering
        // ****************************
        filt(32'h0, 32'h0, STN, 1'b0, 1'b1);
        filt(32'h0, 32'h0, OTH, 1'b0, 1'b0);
        filt(INV, 32'h0, STN, 1'b0, 1'b0);
        filt(INV, 32'h0, OTH, 1'b0, 1'b1);
        filt(MCA, 32'h0, MC, 1'b0, 1'b1);
        filt(MCA, 32'h0, OTH, 1'b0, 1'b0);
        filt(HSEL, 32'hFFFFFFFF, MC, 1'b0, 1'b1);
        filt(HSEL, 32'h0, MC, 1'b0, 1'b0);
        filt(HSEL | INV, 32'hFFFFFFFF, MC, 1'b0, 1'b1);
        filt(HSEL, 32'hFFFFFFFF, OTH, 1'b0, 1'b0);
        filt(HSEL | HO, 32'hFFFFFFFF, OTH, 1'b0, 1'b1);
        filt(HSEL | HO, 32'h0, STN, 1'b0, 1'b0);
        filt(ANY | INV, 32'h0, STN, 1'b0, 1'b1);
        filt(ANY | HSEL | HO, 32'h0, OTH, 1'b0, 1'b1);
        filt(PERR, 32'h0, STN, 1'b1, 1'b1);
        filt(32'h0, 32'h0, STN, 1'b1, 1'b0);
        $display("test filtering done");
        // ****************************
        // collisions
        // ****************************
        wr_reg(OFF_MAC_CONTROL, LRT);
        coll_chk(1'b1, 3'b101);
        wr_reg(OFF_MAC_CONTROL, 32'h0);
        coll_chk(1'b1, 3'b011);
        coll_chk(1'b0, 3'b100);
        $display("test collisions done");
        // ****************************
        // loopback and full duplex
        // ****************************
        wr_reg(OFF_MAC_CONTROL, FDX);
        wr_reg(OFF_MAC_CONTROL, FDX | LOOP);
        rd_chk(OFF_MODE_STATUS, 32'h2);
        repeat (SETTLE + 5) @(posedge clk);
        rd_chk(OFF_MODE_STATUS, 32'h1);
        base = got;
        tx_frame(STN);
        rx_verdict(1'b1);
        check("phy_bytes", {16'h0, base}, {16'h0, got});
        wr_reg(OFF_MAC_CONTROL, FDX);
        repeat (SETTLE + 5) @(posedge clk);
        fork
            tx_frame(OTH);
            u_phy.send(STN, 1'b0);
        join
        rx_verdict(1'b1);
        repeat (4) @(posedge clk);
        check("phy_bytes", {16'h0, base + 16'h8}, {16'h0, got});
        $display("test loopback done");
        final_report();
    end
endmodule
